// ---- src/ahl_axis_homing.v ----
// Four-axis homing sequencer with hardware and software travel limits.
// Assumes config ports are static while used; pins are asynchronous.
`timescale 1ns/1ps
`include "ahl_defines.vh"
// How it works
// RQ1: Signed home offset, clamped to plus/minus 7e13
// RQ2: After marker, move offset, then zero position
// RQ3: Fast switch-to-marker move, then 2000 steps/s
// RQ4: Zero switch-to-marker distance starts slow search
// RQ5: Software signs distance by switch side
// RQ6: Resolver mode homes to resolver null
// RQ7: Home switch released only after hold time
// RQ8: Per-axis limit polarity, normally open default
// RQ9: Limit hit computes stop-in-distance deceleration
// RQ10: Larger max rate replaces computed rate
// RQ11: Stop distance default 2000; zero uses max
// RQ12: CCW soft limit from home, after homing
// RQ13: CCW soft limit default most negative value
// RQ14: CW soft limit from home, after homing
// RQ15: CW soft limit default largest value
// RQ16: Soft limit checking enabled by default
// RQ17: Runtime home cycles use normal feedrate
// RQ18: Reverse out of home switch first
// RQ19: Open limit switch reads high
// RQ20: Active limit = raw level with polarity
// RQ21: Homed flag gates soft limits
module ahl_axis_homing #(
    parameter TICK_CYC = `AHL_TICK_CYC
) (
    // Clock and reset
    input  wire           clock,
    input  wire           rst,
    // Commands
    input  wire [3:0]     homeStart,
    // Per-axis switches and modes
    input  wire [3:0]     homeDirCcw,
    input  wire [3:0]     homeSwNormOpen,
    input  wire [3:0]     limitSwitchPolarity,
    input  wire [3:0]     resolverMode,
    input  wire [3:0]     softLimitDisable,
    // Per-axis rates, Q16.16: feedrates in steps per ms, accel rate in steps per ms per ms
    input  wire [127:0]   powerOnFeedrate,
    input  wire [127:0]   normalHomeFeedrate,
    input  wire [127:0]   maxAccelDecelRate,
    // Per-axis distances and limits, steps; debounce time in ms
    input  wire [191:0]   homeOffsetSteps,
    input  wire [191:0]   switchToMarkerDistance,
    input  wire [91:0]    homeSwitchDebounceTime,
    input  wire [95:0]    stopDistanceSteps,
    input  wire [191:0]   ccwSoftLimit,
    input  wire [191:0]   cwSoftLimit,
    // Pins
    input  wire [3:0]     homeSwPin,
    input  wire [3:0]     cwLimitPin,
    input  wire [3:0]     ccwLimitPin,
    input  wire [3:0]     markerPin,
    input  wire [3:0]     resolverNullPin,
    // Status
    output wire [127:0]   velCmd,
    output wire [191:0]   axisPos,
    output wire [3:0]     homed,
    output wire [3:0]     homing,
    output wire [3:0]     hwLimitFault,
    output wire [3:0]     softLimitFault
);
    localparam S_IDLE = 3'h0;
    localparam S_SEEK = 3'h1;
    localparam S_BACK = 3'h2;
    localparam S_FAST = 3'h3;
    localparam S_SLOW = 3'h4;
    localparam S_OFFS = 3'h5;

    function [47:0] absVal;
        input [47:0] v;
        begin
            absVal = v[47] ? (~v + 48'h1) : v;
        end
    endfunction

    function limitActive;
        input pinLvl;
        input normOpen;
        begin
            limitActive = pinLvl ^ normOpen; // RQ19
        end
    endfunction

    // ----------------------------------------
    // Tick divider and pin synchronisers
    // ----------------------------------------
    reg  [31:0] div_q;
    reg         tick_q;
    reg  [19:0] sync1_q;
    reg  [19:0] sync2_q;
    wire [19:0] pinsIn = {resolverNullPin, markerPin, ccwLimitPin, cwLimitPin,
                          homeSwPin};

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            div_q   <= 32'h0;
            tick_q  <= 1'b0;
            sync1_q <= 20'h00FF0;
            sync2_q <= 20'h00FF0;
        end else begin
            sync1_q <= pinsIn;
            sync2_q <= sync1_q;
            tick_q  <= (div_q == TICK_CYC - 1);
            div_q   <= (div_q == TICK_CYC - 1) ? 32'h0 : div_q + 32'h1;
        end
    end

    // ----------------------------------------
    // Per-axis sequencer
    // ----------------------------------------
    genvar a;
    generate
        for (a = 0; a < 4; a = a + 1) begin : g_axis
            reg        [2:0]  st_q;
            reg signed [31:0] vel_q;
            reg signed [63:0] acc_q;
            reg signed [47:0] start_q;
            reg               homed_q;
            reg               homing_q;
            reg               poDone_q;
            reg               mark_q;
            reg               refPrev_q;
            reg               stopping_q;
            reg               hwF_q;
            reg               swF_q;
            reg               backNeg_q;
            reg signed [31:0] tv;
            reg        [31:0] feed;
            wire              homeAct;
            wire       [31:0] stopRate;
            wire              rateBusy;

            wire signed [47:0] posInt  = acc_q[63:16];
            wire signed [47:0] moved   = posInt - start_q;
            wire signed [47:0] offRaw  = $signed(homeOffsetSteps[a*48 +: 48]);
            wire signed [47:0] offMax  = `AHL_OFFSET_MAX;
            wire signed [47:0] offset  = (offRaw > offMax) ? offMax :
                                         (offRaw < -offMax) ? -offMax : offRaw; // RQ1
            wire signed [47:0] s2m     = $signed(switchToMarkerDistance[a*48 +: 48]);
            wire signed [47:0] ccwLim  = $signed(ccwSoftLimit[a*48 +: 48]); // RQ13
            wire signed [47:0] cwLim   = $signed(cwSoftLimit[a*48 +: 48]); // RQ15
            wire        [31:0] nFeed   = normalHomeFeedrate[a*32 +: 32];
            wire        [31:0] maxAcc  = maxAccelDecelRate[a*32 +: 32];
            wire        [31:0] slowVel = `AHL_SLOW_VEL;

            // ----------------------------------------
            // Switch decode
            // ----------------------------------------
            // Open switch reads high through pull-up
            wire cwAct  = limitActive(sync2_q[4+a], limitSwitchPolarity[a]); // RQ19 RQ20 RQ8
            wire ccwAct = limitActive(sync2_q[8+a], limitSwitchPolarity[a]); // RQ20 RQ8
            wire homeSw = sync2_q[a] ^ ~homeSwNormOpen[a];
            wire refLvl = resolverMode[a] ? sync2_q[16+a] : sync2_q[12+a]; // RQ6
            wire hwHit  = (cwAct & (vel_q > 0)) | (ccwAct & (vel_q < 0)); // RQ9
            wire swHit  = homed_q & ~softLimitDisable[a] &
                          ((posInt < ccwLim) | (posInt > cwLim)); // RQ12 RQ14 RQ16 RQ21
            wire [31:0] ac = stopping_q ? (rateBusy ? maxAcc : stopRate) : maxAcc;
            wire signed [32:0] up   = vel_q + $signed({1'b0, ac});
            wire signed [32:0] down = vel_q - $signed({1'b0, ac});
            wire signed [32:0] tvX  = {tv[31], tv};

            // ----------------------------------------
            // Release filter and stop-rate divider
            // ----------------------------------------
            ahl_debounce u_deb (
                .clock        (clock),
                .rst          (rst),
                .msTick       (tick_q),
                .holdMs       (homeSwitchDebounceTime[a*23 +: 23]),
                .swActive     (homeSw),
                .homeActive_q (homeAct)
            );

            ahl_stop_rate u_rate (
                .clock    (clock),
                .rst      (rst),
                .start    ((hwHit | swHit) & ~stopping_q),
                .speed    (vel_q[31] ? -vel_q : vel_q),
                .stopDist (stopDistanceSteps[a*24 +: 24]),
                .maxAccel (maxAcc),
                .rate_q   (stopRate),
                .busy_q   (rateBusy)
            );

            // ----------------------------------------
            // Target velocity of each phase
            // ----------------------------------------
            always @* begin
                feed = poDone_q ? nFeed : powerOnFeedrate[a*32 +: 32]; // RQ17
                tv   = 32'sh0;
                if (!stopping_q) begin
                    case (st_q)
                        S_SEEK:  tv = homeDirCcw[a] ? -$signed(feed) : $signed(feed);
                        S_BACK:  tv = homeDirCcw[a] ? $signed(feed) : -$signed(feed); // RQ18
                        S_FAST:  tv = s2m[47] ? -$signed(nFeed) : $signed(nFeed); // RQ3 RQ5
                        S_SLOW:  tv = backNeg_q ? -$signed(slowVel) : $signed(slowVel); // RQ3
                        S_OFFS:  tv = offset[47] ? -$signed(nFeed) : $signed(nFeed); // RQ2
                        default: tv = 32'sh0;
                    endcase
                end
            end

            // ----------------------------------------
            // Phase sequencer
            // ----------------------------------------
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    st_q       <= S_IDLE;
                    vel_q      <= 32'sh0;
                    acc_q      <= 64'sh0;
                    start_q    <= 48'sh0;
                    homed_q    <= 1'b0; // RQ21
                    homing_q   <= 1'b0;
                    poDone_q   <= 1'b0;
                    mark_q     <= 1'b0;
                    refPrev_q  <= 1'b0;
                    stopping_q <= 1'b0;
                    hwF_q      <= 1'b0;
                    swF_q      <= 1'b0;
                    backNeg_q  <= 1'b0;
                end else begin
                    refPrev_q <= refLvl;
                    hwF_q     <= hwHit;
                    swF_q     <= swHit;
                    homing_q  <= (st_q != S_IDLE);
                    if (st_q == S_SLOW && refLvl && !refPrev_q) begin
                        mark_q <= 1'b1;
                    end
                    if ((hwHit | swHit) && !stopping_q) begin
                        stopping_q <= 1'b1; // RQ9
                        st_q       <= S_IDLE;
                        mark_q     <= 1'b0;
                    end else if (homeStart[a] && !stopping_q) begin
                        st_q      <= S_SEEK;
                        homed_q   <= 1'b0;
                        mark_q    <= 1'b0;
                        backNeg_q <= ~homeDirCcw[a];
                    end else if (tick_q) begin
                        if (vel_q < tv) begin
                            vel_q <= (up > tvX) ? tv : up[31:0];
                        end else begin
                            vel_q <= (down < tvX) ? tv : down[31:0];
                        end
                        acc_q <= acc_q + {{32{vel_q[31]}}, vel_q};
                        if (stopping_q && vel_q == 32'sh0) begin
                            stopping_q <= 1'b0;
                        end
                        case (st_q)
                            S_SEEK: begin
                                if (homeAct) begin
                                    st_q <= S_BACK; // RQ18
                                end
                            end
                            S_BACK: begin
                                if (!homeAct) begin
                                    start_q <= posInt;
                                    st_q    <= (s2m == 48'sh0) ? S_SLOW : S_FAST; // RQ4
                                    if (s2m != 48'sh0) begin
                                        backNeg_q <= s2m[47];
                                    end
                                end
                            end
                            S_FAST: begin
                                if (absVal(moved) >= absVal(s2m)) begin
                                    st_q <= S_SLOW; // RQ3
                                end
                            end
                            S_SLOW: begin
                                if (mark_q) begin
                                    mark_q  <= 1'b0;
                                    start_q <= posInt;
                                    st_q    <= S_OFFS; // RQ2 RQ6
                                end
                            end
                            S_OFFS: begin
                                if (absVal(moved) >= absVal(offset)) begin
                                    acc_q    <= 64'sh0; // RQ2
                                    vel_q    <= 32'sh0;
                                    homed_q  <= 1'b1; // RQ21
                                    poDone_q <= 1'b1;
                                    st_q     <= S_IDLE;
                                end
                            end
                            default: st_q <= S_IDLE;
                        endcase
                    end
                end
            end

            // ----------------------------------------
            // Status outputs
            // ----------------------------------------
            assign velCmd[a*32 +: 32]  = vel_q;
            assign axisPos[a*48 +: 48] = acc_q[63:16];
            assign homed[a]            = homed_q;
            assign homing[a]           = homing_q;
            assign hwLimitFault[a]     = hwF_q;
            assign softLimitFault[a]   = swF_q;
        end
    endgenerate
endmodule // ahl_axis_homing

// ---- src/ahl_defines.vh ----
// Widths, defaults and timing for the axis homing and limit block.
// Included by every design file of the block; definitions only.
`ifndef AHL_DEFINES_VH
`define AHL_DEFINES_VH
`define AHL_AXES          4
`define AHL_POS_W         48
`define AHL_VEL_W         32
`define AHL_FRAC_W        16
`define AHL_STOPD_W       24
`define AHL_DEB_W         23
`define AHL_CLK_NS        10
`define AHL_TICK_NS       1000000
`define AHL_TICK_CYC      (`AHL_TICK_NS / `AHL_CLK_NS)
`define AHL_SLOW_SPS      2000
`define AHL_SLOW_VEL      ((`AHL_SLOW_SPS * 65536) / 1000)
`define AHL_OFFSET_MAX    48'h3FAA_2522_6000
`define AHL_DEF_DEB_MS    100
`define AHL_DEF_STOP_DIST 2000
`define AHL_CCW_DEF       48'h8000_0000_0000
`define AHL_CW_DEF        48'h7FFF_FFFF_FFFF
`endif

// ---- src/ahl_debounce.v ----
// Home switch release filter: on at once, off after a hold time.
// Assumes a synchronised active-high input and a 1 ms tick pulse.
`timescale 1ns/1ps
`include "ahl_defines.vh"
module ahl_debounce (
    // Clock and reset
    input  wire                  clock,
    input  wire                  rst,
    // Timing
    input  wire                  msTick,
    input  wire [`AHL_DEB_W-1:0] holdMs,
    // Switch
    input  wire                  swActive,
    output reg                   homeActive_q
);
    reg [`AHL_DEB_W-1:0] cnt_q;

    // ----------------------------------------
    // Release hysteresis
    // ----------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q        <= {`AHL_DEB_W{1'b0}};
            homeActive_q <= 1'b0;
        end else if (swActive) begin
            cnt_q        <= {`AHL_DEB_W{1'b0}};
            homeActive_q <= 1'b1;
        end else if (homeActive_q) begin
            if (cnt_q >= holdMs) begin
                homeActive_q <= 1'b0; // RQ7
            end else if (msTick) begin
                cnt_q <= cnt_q + 1'b1; // RQ7
            end
        end
    end
endmodule // ahl_debounce

// ---- src/ahl_stop_rate.v ----
// Serial divider giving the deceleration that stops within a distance.
// Assumes start is a pulse; result is valid when busy falls.
`timescale 1ns/1ps
`include "ahl_defines.vh"
module ahl_stop_rate (
    // Clock and reset
    input  wire                    clock,
    input  wire                    rst,
    // Request
    input  wire                    start,
    input  wire [`AHL_VEL_W-1:0]   speed,
    input  wire [`AHL_STOPD_W-1:0] stopDist,
    input  wire [`AHL_VEL_W-1:0]   maxAccel,
    // Result
    output reg  [`AHL_VEL_W-1:0]   rate_q,
    output reg                     busy_q
);
    wire [63:0] square = speed * speed;
    wire [24:0] den    = {stopDist, 1'b0};
    reg  [47:0] quo_q;
    reg  [48:0] rem_q;
    reg  [5:0]  cnt_q;
    wire [48:0] trial  = {rem_q[47:0], quo_q[47]};
    wire        fits   = trial >= {24'h000000, den};
    wire [47:0] quoN   = {quo_q[46:0], fits};
    wire [31:0] quoSat = (quoN[47:32] != 16'h0000) ? 32'hFFFF_FFFF : quoN[31:0];

    // ----------------------------------------
    // Rate = v*v / (2*d), never below max
    // ----------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            quo_q  <= 48'h0;
            rem_q  <= 49'h0;
            cnt_q  <= 6'h00;
            rate_q <= 32'h0;
            busy_q <= 1'b0;
        end else if (start) begin
            quo_q  <= square[63:16]; // RQ9
            rem_q  <= 49'h0;
            cnt_q  <= 6'h00;
            busy_q <= 1'b1;
            rate_q <= maxAccel;
        end else if (busy_q) begin
            quo_q <= quoN;
            rem_q <= fits ? (trial - {24'h000000, den}) : trial;
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h2F) begin
                busy_q <= 1'b0;
                if (stopDist == {`AHL_STOPD_W{1'b0}}) begin
                    rate_q <= maxAccel; // RQ11
                end else begin
                    rate_q <= (maxAccel > quoSat) ? maxAccel : quoSat; // RQ10
                end
            end
        end
    end
endmodule // ahl_stop_rate

// ---- sim/ahl_axis_homing_properties.sv ----
// Checker for the axis homing block, bound to its top module.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module ahl_axis_homing_checker #(
    parameter TICK_CYC = 100
) (
    // Clock and reset
    input wire         clock,
    input wire         rst,
    // Inputs watched
    input wire [3:0]   homeStart,
    input wire [3:0]   limitSwitchPolarity,
    input wire [3:0]   softLimitDisable,
    input wire [3:0]   cwLimitPin,
    input wire [3:0]   ccwLimitPin,
    // Status watched
    input wire [127:0] velCmd,
    input wire [191:0] axisPos,
    input wire [3:0]   homed,
    input wire [3:0]   homing,
    input wire [3:0]   hwLimitFault,
    input wire [3:0]   softLimitFault
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    wire [3:0] limAct = (cwLimitPin ^ limitSwitchPolarity) | (ccwLimitPin ^ limitSwitchPolarity);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_reset_clears: assert property (disable iff (1'b0)
        rst && $past(rst) |-> (homed | homing | hwLimitFault | softLimitFault) == 4'h0
        && velCmd == 128'h0) else $error("outputs not cleared in reset");
    a_start_homing: assert property (homeStart[0] && velCmd[31:0] == 32'h0
        && !hwLimitFault[0] |-> ##[1:2] homing[0]) else $error("home start not taken");
    a_homing_ends: assert property ($rose(homed[0]) |-> homing[0] ##1 !homing[0])
        else $error("homing did not end after homed");
    a_pos_zeroed: assert property ($rose(homed[0]) |-> axisPos[47:0] == 48'h0
        && velCmd[31:0] == 32'h0) else $error("position not zeroed at homed");
    a_homed_holds: assert property (homed[0] && !homeStart[0] |=> homed[0])
        else $error("homed dropped without start");
    a_soft_homed: assert property ((softLimitFault & ~($past(homed) | $past(homed, 2)))
        == 4'h0) else $error("soft fault on unhomed axis");
    a_soft_enable: assert property ((softLimitFault & $past(softLimitDisable)
        & $past(softLimitDisable, 2)) == 4'h0) else $error("soft fault while disabled");
    a_limit_cause: assert property ((hwLimitFault & ~$past(hwLimitFault)
        & ~($past(limAct, 2) | $past(limAct, 3) | $past(limAct, 4))) == 4'h0)
        else $error("limit fault without active switch");
    c_homed: cover property ($rose(homed[0]));
    c_hw_hit: cover property ($rose(hwLimitFault[2]));
    c_soft_hit: cover property ($rose(softLimitFault[0]));
endmodule // ahl_axis_homing_checker

bind ahl_axis_homing ahl_axis_homing_checker #(.TICK_CYC(TICK_CYC)) u_ahl_axis_homing_checker (
    .clock(clock), .rst(rst), .homeStart(homeStart), .limitSwitchPolarity(limitSwitchPolarity),
    .softLimitDisable(softLimitDisable), .cwLimitPin(cwLimitPin), .ccwLimitPin(ccwLimitPin),
    .velCmd(velCmd), .axisPos(axisPos), .homed(homed), .homing(homing),
    .hwLimitFault(hwLimitFault), .softLimitFault(softLimitFault));

// ---- sim/ahl_switch_model.sv ----
// Stage model: integrates commanded velocity and drives switch pins.
// Assumes velocity in Q16.16 steps per tick of TICK_CYC cycles.
`timescale 1ns/1ps
module ahl_switch_model #(
    parameter TICK_CYC = 100
) (
    // Clock and reset
    input  wire         clock,
    input  wire         rst,
    // Motion and settings
    input  wire [127:0] velCmd,
    input  wire [3:0]   limitSwitchPolarity,
    input  wire [3:0]   homeSwNormOpen,
    input  wire [3:0]   markerEnable,
    // Pins and stage position
    output logic [3:0]   homeSwPin,
    output logic [3:0]   cwLimitPin,
    output logic [3:0]   ccwLimitPin,
    output logic [3:0]   markerPin,
    output logic [3:0]   resolverNullPin,
    output logic [191:0] stepPos
);
    int     tickCnt;
    longint acc [0:3];
    always @(posedge clock or posedge rst) begin : motion
        int i;
        if (rst) begin
            tickCnt <= 0;
            for (i = 0; i < 4; i++) acc[i] <= 0;
        end else begin
            tickCnt <= (tickCnt == TICK_CYC - 1) ? 0 : tickCnt + 1;
            for (i = 0; i < 4; i++)
                if (tickCnt == TICK_CYC - 1) acc[i] <= acc[i] + $signed(velCmd[i*32 +: 32]);
        end
    end
    always_comb begin : pins
        int j;
        longint p;
        p = 0;
        for (j = 0; j < 4; j++) begin
            p = acc[j] >>> 16;
            homeSwPin[j] = (p <= ((j < 2) ? -1000 : -1000000)) ^ ~homeSwNormOpen[j];
            ccwLimitPin[j] = (p <= ((j < 2) ? -100000 : -300)) ^ limitSwitchPolarity[j];
            cwLimitPin[j] = (p >= 100000) ^ limitSwitchPolarity[j];
            markerPin[j] = markerEnable[j] && ((p % 200) + 200) % 200 < 4;
            resolverNullPin[j] = ((p % 250) + 250) % 250 < 4;
            stepPos[j*48 +: 48] = p[47:0];
        end
    end
endmodule // ahl_switch_model

// ---- sim/test_ahl_axis_homing.sv ----
// Self-checking bench for the axis homing block with a stage model.
// Assumes a 100 MHz clock and a shortened 100-cycle servo tick.
`timescale 1ns/1ps
module test_ahl_axis_homing;
    localparam TICK = 100;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic         clock = 0, rst = 1, slowSeen = 0;
    logic [3:0]   homeStart = 4'h0, softDis = 4'h0;
    logic [191:0] s2m = 192'h0, ccwLim = {4{48'h8000_0000_0000}}, cwLim = {4{48'h7FFF_FFFF_FFFF}};
    logic [31:0]  peak0 = 32'h0;
    logic [3:0]   limPol = 4'hB, swNo = 4'hF;
    logic [95:0]  stopD = {24'h0, {3{24'h000005}}};
    logic [127:0] poFeed = {4{32'h0014_0000}}, nFeed = {4{32'h0019_0000}};
    logic [127:0] maxAcc = {32'h0002_0000, {3{32'h0005_0000}}};
    wire  [127:0] velCmd;
    wire  [191:0] axisPos, stepPos;
    wire  [3:0]   homed, homing, hwLimitFault, softLimitFault, homeSw, cwPin, ccwPin, mk, nul;
    wire  [31:0]  abs0 = velCmd[31] ? -velCmd[31:0] : velCmd[31:0];
    int           failures = 0, compares = 0;
    always #5 clock = ~clock;
    always @(posedge clock) begin
        if (homing[0] && abs0 > peak0) peak0 <= abs0;
        if (homing[0] && velCmd[31:0] == 32'h0002_0000) slowSeen <= 1'b1;
    end
    ahl_axis_homing #(.TICK_CYC(TICK)) u_ahl_axis_homing (
        .clock(clock), .rst(rst), .homeStart(homeStart), .homeDirCcw(4'hF),
        .homeSwNormOpen(swNo), .limitSwitchPolarity(limPol), .resolverMode(4'h2),
        .softLimitDisable(softDis), .powerOnFeedrate(poFeed), .normalHomeFeedrate(nFeed),
        .maxAccelDecelRate(maxAcc),
        .homeOffsetSteps({4{48'h0000_0000_000A}}), .switchToMarkerDistance(s2m),
        .homeSwitchDebounceTime({4{23'h000003}}), .stopDistanceSteps(stopD),
        .ccwSoftLimit(ccwLim), .cwSoftLimit(cwLim), .homeSwPin(homeSw), .cwLimitPin(cwPin),
        .ccwLimitPin(ccwPin), .markerPin(mk), .resolverNullPin(nul), .velCmd(velCmd),
        .axisPos(axisPos), .homed(homed), .homing(homing), .hwLimitFault(hwLimitFault),
        .softLimitFault(softLimitFault));
    ahl_switch_model #(.TICK_CYC(TICK)) u_ahl_switch_model (
        .clock(clock), .rst(rst), .velCmd(velCmd), .limitSwitchPolarity(limPol),
        .homeSwNormOpen(swNo), .markerEnable(4'hD), .homeSwPin(homeSw), .cwLimitPin(cwPin),
        .ccwLimitPin(ccwPin), .markerPin(mk), .resolverNullPin(nul), .stepPos(stepPos));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic pick(input int sel, input int a);
        if (sel == 0) return homed[a];
        if (sel == 1) return hwLimitFault[a];
        return velCmd[a*32 +: 32] == 32'h0;
    endfunction
    task automatic waitFor(input int sel, input int a);
        int n;
        for (n = 0; pick(sel, a) !== 1'b1; n++) begin
            @(negedge clock);
            if (n > 40000) begin
                failures++;
                $display("[ERR] wait %0d axis %0d expected 1 seen 0", sel, a);
                test_done();
            end
        end
    endtask
    function automatic longint pos(input int a);
        return $signed(stepPos[a*48 +: 48]);
    endfunction
    task automatic pulse(input logic [3:0] m);
        @(negedge clock) homeStart = m;
        @(negedge clock) homeStart = 4'h0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_home(input logic [31:0] feed, input logic first);
        peak0 = 32'h0;
        slowSeen = 1'b0;
        pulse(first ? 4'h3 : 4'h1);
        repeat (3) @(negedge clock);
        check("homed cleared", homed[0], 1'b0);
        waitFor(0, 0);
        check("axis0 position", axisPos[47:0], 48'h0);
        check("axis0 peak feed", peak0, feed);
        check("axis0 slow search", slowSeen, 1'b1);
        if (first) begin
            check("axis0 offset travel", pos(0) + 800 inside {[10:35]}, 1'b1);
            waitFor(0, 1);
            check("axis1 homed on null", homed[1], 1'b1);
        end
        $display("home test done");
    endtask
    task automatic t_soft;
        softDis = 4'h1;
        cwLim[47:0] = 48'hFFFF_FFFF_FFFF;
        cwLim[191:144] = 48'hFFFF_FFFF_FFFF;
        repeat (5) @(negedge clock);
        check("soft fault disabled", softLimitFault, 4'h0);
        softDis = 4'h0;
        repeat (5) @(negedge clock);
        check("cw soft fault", softLimitFault, 4'h1);
        cwLim = {4{48'h7FFF_FFFF_FFFF}};
        ccwLim = {4{48'h0000_0000_0001}};
        repeat (5) @(negedge clock);
        check("ccw soft fault", softLimitFault, 4'h3);
        ccwLim = {4{48'h8000_0000_0000}};
        repeat (5) @(negedge clock);
        check("soft fault cleared", softLimitFault, 4'h0);
        $display("soft limit test done");
    endtask
    task automatic t_hw_limit;
        longint p2, p3;
        pulse(4'hC);
        waitFor(1, 2);
        p2 = pos(2);
        check("axis2 closed switch fault", hwLimitFault[2], 1'b1);
        waitFor(1, 3);
        p3 = pos(3);
        waitFor(2, 2);
        waitFor(2, 3);
        repeat (3 * TICK) @(negedge clock);
        check("axis2 short stop", p2 - pos(2) <= 45, 1'b1);
        check("axis3 max rate stop", p3 - pos(3) >= 80, 1'b1);
        check("limit aborts homing", homing[3:2], 2'h0);
        $display("hw limit test done");
    endtask
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        check("reset status", {homed, homing, hwLimitFault, softLimitFault}, 16'h0);
        t_home(32'h0014_0000, 1'b1);
        s2m[47:0] = 48'h0000_0000_0064;
        t_home(32'h0019_0000, 1'b0);
        t_soft();
        t_hw_limit();
        test_done();
    end
endmodule // test_ahl_axis_homing
